// [orkp_defs.svh]
// Constant definitions for the OR elements and key pulser block
`ifndef ORKP_DEFS_SVH
`define ORKP_DEFS_SVH
// Register byte offsets
`define OFS_OR2_CTRL 12'h000
`define OFS_OR4_CTRL 12'h004
`define OFS_OR8_CTRL 12'h008
`define OFS_OR_IN 12'h00C
`define OFS_OR_STATUS 12'h010
`define OFS_KEY_GROUP 12'h014
`define OFS_KEY_STATUS 12'h018
// Field positions in the operand input register
`define POS_OR2_IN 0
`define POS_OR4_IN 2
`define POS_OR8_IN 6
// Field positions in the key status register
`define POS_KEY_FB 0
`define POS_KEY_RAW 4
// Reset values
`define RST_INVERT 32'h0000_0000
`define RST_GROUP 2'h0
// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [orkp_pkg.sv]
// Types shared by the OR elements and key pulser block
package orkp_pkg;
    // Read data returned on the AXI4-Lite read channel
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_answer_s;
    // Write acceptance state
    typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_e;
endpackage

// [or_gates_and_key_pulser.sv]
// OR elements with per-input inversion and grouped operator key pulser
//
// Contract
// - Two-input OR low only when both low.
// - Two-input OR high if either high.
// - Two-input OR inverts each input separately.
// - Inverted input flips level before OR.
// - Four-input OR is any-high OR.
// - Four-input OR inverts each input separately.
// - Eight-input OR is any-high OR.
// - Eight-input OR inverts each input separately.
// - Unconnected inputs read zero before inversion.
// - Each key press gives one pulse.
// - Four units, sixteen pulse outputs total.
// - Selected group alone receives key pulses.
// - Feedback per key passed to display.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "orkp_defs.svh"
module or_gates_and_key_pulser
    import orkp_pkg::*;
#(
    parameter int GROUPS = 4, // Number of key pulse units
    parameter int KEYS = 4 // Function keys per unit
) (
    input wire logic CLK, // 100 MHz clock
    input wire logic RST, // Asynchronous reset, active high
    input wire logic [11:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [11:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic [KEYS-1:0] KEY_PRESSED, // Keypad keys, high while held
    input wire logic [GROUPS*KEYS-1:0] FEEDBACK_SIGNALS, // Feedback per unit key
    output logic [GROUPS*KEYS-1:0] KEY_PULSE, // One-shot pulses, unit major
    output logic [KEYS-1:0] KEY_FEEDBACK_OUT, // Feedback shown beside each key
    output logic TWO_INPUT_OR_OUT, // Two-input OR result
    output logic FOUR_INPUT_OR_OUT, // Four-input OR result
    output logic EIGHT_INPUT_OR_OUT // Eight-input OR result
);
    localparam int GW = $clog2(GROUPS); // Group select width
    localparam logic [GROUPS*KEYS-1:0] UNIT_MASK = (GROUPS*KEYS)'((1 << KEYS) - 1); // One unit

    logic [1:0] or2_inv_reg; // Two-input inversion options
    logic [3:0] or4_inv_reg; // Four-input inversion options
    logic [7:0] or8_inv_reg; // Eight-input inversion options
    logic [13:0] or_in_reg; // Operand levels written by software
    logic [GW-1:0] group_reg; // Selected key group
    logic [KEYS-1:0] key_prev_reg; // Key levels one scan ago
    logic [31:0] wr_old; // Present word at the write address
    logic [31:0] wr_word; // Present word merged with strobed data
    logic aw_done_reg; // Write address taken
    logic w_done_reg; // Write data taken
    logic [11:0] aw_addr_reg; // Held write address
    logic [31:0] w_data_reg; // Held write data
    logic [3:0] w_strb_reg; // Held write strobes
    rd_answer_s rd_next; // Read answer before registering
    logic [KEYS-1:0] key_rise; // Press edges this scan
    logic wr_fire; // Write commits this cycle

    // Applies inversion options to operand levels
    function automatic logic [7:0] effective(input logic [7:0] lvl, input logic [7:0] inv);
        effective = lvl ^ inv;
    endfunction

    // Merges a strobed write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = m;
    endfunction

    // Write channel handshakes: each channel is taken independently
    assign S_AXI_AWREADY = !aw_done_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_done_reg && !S_AXI_BVALID;
    assign wr_fire = aw_done_reg && w_done_reg && !S_AXI_BVALID;

    // Captures write address and data in either order
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_done_reg <= 1'b0;
            w_done_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_done_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_done_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_done_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_done_reg <= 1'b0;
            end
        end
    end

    // Write response, error for unmapped or read-only addresses
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr_reg)
                `OFS_OR2_CTRL, `OFS_OR4_CTRL, `OFS_OR8_CTRL, `OFS_OR_IN,
                `OFS_KEY_GROUP: S_AXI_BRESP <= `RESP_OKAY;
                default: S_AXI_BRESP <= `RESP_SLVERR;
            endcase
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Present contents of the addressed register, merged with the held write
    // Unstrobed bytes keep their old value this way
    always_comb begin
        case (aw_addr_reg)
            `OFS_OR2_CTRL: wr_old = {30'h0, or2_inv_reg};
            `OFS_OR4_CTRL: wr_old = {28'h0, or4_inv_reg};
            `OFS_OR8_CTRL: wr_old = {24'h0, or8_inv_reg};
            `OFS_OR_IN: wr_old = {18'h0, or_in_reg};
            `OFS_KEY_GROUP: wr_old = {{(32-GW){1'b0}}, group_reg};
            default: wr_old = 32'h0000_0000;
        endcase
        wr_word = merge(wr_old, w_data_reg, w_strb_reg);
    end

    // Control registers written by software
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            or2_inv_reg <= 2'h0;
            or4_inv_reg <= 4'h0;
            or8_inv_reg <= 8'h00;
            or_in_reg <= 14'h0000;
            group_reg <= '0;
        end else if (wr_fire) begin
            case (aw_addr_reg)
                `OFS_OR2_CTRL: or2_inv_reg <= wr_word[1:0];
                `OFS_OR4_CTRL: or4_inv_reg <= wr_word[3:0];
                `OFS_OR8_CTRL: or8_inv_reg <= wr_word[7:0];
                `OFS_OR_IN: or_in_reg <= wr_word[13:0];
                `OFS_KEY_GROUP: group_reg <= wr_word[GW-1:0];
                default: ;
            endcase
        end
    end

    // OR elements: unused operands default to zero, evaluated once per scan
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TWO_INPUT_OR_OUT <= 1'b0;
            FOUR_INPUT_OR_OUT <= 1'b0;
            EIGHT_INPUT_OR_OUT <= 1'b0;
        end else begin
            TWO_INPUT_OR_OUT <= |effective({6'h00, or_in_reg[`POS_OR2_IN +: 2]},
                                           {6'h00, or2_inv_reg});
            FOUR_INPUT_OR_OUT <= |effective({4'h0, or_in_reg[`POS_OR4_IN +: 4]},
                                            {4'h0, or4_inv_reg});
            EIGHT_INPUT_OR_OUT <= |effective(or_in_reg[`POS_OR8_IN +: 8],
                                             or8_inv_reg);
        end
    end

    // Two-input OR is low only when both effective operands were low
    AST_OR2_LOW: assert property (
        @(posedge CLK) disable iff (RST)
        ##1 !TWO_INPUT_OR_OUT |-> $past((or_in_reg[1:0] ^ or2_inv_reg) == 2'b00))
        else $error("two-input OR low with an active operand");

    // Any active two-input operand drives the output high next scan
    AST_OR2_HIGH: assert property (
        @(posedge CLK) disable iff (RST)
        ((or_in_reg[1:0] ^ or2_inv_reg) != 2'b00) |=> TWO_INPUT_OR_OUT)
        else $error("two-input OR missed an active operand");

    // Both operands inverted and both high gives a low output
    AST_OR2_INV: assert property (
        @(posedge CLK) disable iff (RST)
        (or2_inv_reg == 2'b11 && or_in_reg[1:0] == 2'b11) |=> !TWO_INPUT_OR_OUT)
        else $error("two-input OR inversion not applied");

    // Inversion flips each level before the OR, in every combination
    AST_OR2_EXACT: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> TWO_INPUT_OR_OUT == $past(|(or_in_reg[1:0] ^ or2_inv_reg)))
        else $error("two-input OR result wrong");

    // Four-input result follows its effective operands one scan later
    AST_OR4: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> FOUR_INPUT_OR_OUT == $past(|(or_in_reg[5:2] ^ or4_inv_reg)))
        else $error("four-input OR result wrong");

    // Eight-input result follows its effective operands one scan later
    AST_OR8: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> EIGHT_INPUT_OR_OUT == $past(|(or_in_reg[13:6] ^ or8_inv_reg)))
        else $error("eight-input OR result wrong");

    // Press edges: a held key gives no further edge
    assign key_rise = KEY_PRESSED & ~key_prev_reg;

    // Key history and pulse outputs for the selected unit only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            key_prev_reg <= '0;
            KEY_PULSE <= '0;
            KEY_FEEDBACK_OUT <= '0;
        end else begin
            key_prev_reg <= KEY_PRESSED;
            for (int g = 0; g < GROUPS; g++) begin
                KEY_PULSE[g*KEYS +: KEYS] <= (group_reg == g[GW-1:0]) ? key_rise : '0;
            end
            KEY_FEEDBACK_OUT <= FEEDBACK_SIGNALS[group_reg*KEYS +: KEYS];
        end
    end

    // The first key, still held one scan after its press, gives no second pulse on unit 0
    AST_PULSE_ONE: assert property (
        @(posedge CLK) disable iff (RST)
        KEY_PRESSED[0] && !key_prev_reg[0] ##1 KEY_PRESSED[0] |=>
        KEY_PULSE[0 +: 1] == 1'b0 || group_reg != 0)
        else $error("held key retriggered");

    // A press of the second key pulses the unit selected at the press
    AST_PULSE_GROUP: assert property (
        @(posedge CLK) disable iff (RST)
        (KEY_PRESSED[1] && !key_prev_reg[1]) |=> KEY_PULSE[$past(group_reg)*KEYS + 1])
        else $error("press gave no pulse on selected group");

    // No unit other than the selected one ever pulses
    AST_PULSE_ONLY_SEL: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> (KEY_PULSE & ~(UNIT_MASK << ($past(group_reg) * KEYS))) == '0)
        else $error("pulse on a unit that is not selected");

    // The selected unit pulses exactly on the press edges of the scan before
    AST_PULSE_SEL_UNIT: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> KEY_PULSE[$past(group_reg)*KEYS +: KEYS] == $past(key_rise))
        else $error("selected unit pulses differ from press edges");

    // Every pulse output falls after one scan
    AST_PULSE_SHORT: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> (KEY_PULSE & $past(KEY_PULSE)) == '0)
        else $error("pulse lasted more than one scan");

    // Shown feedback is that of the selected unit, one scan late
    AST_FEEDBACK: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> KEY_FEEDBACK_OUT == $past(FEEDBACK_SIGNALS[group_reg*KEYS +: KEYS]))
        else $error("feedback not taken from selected unit");

    // Read decode
    always_comb begin
        rd_next.data = 32'h0000_0000;
        rd_next.resp = `RESP_OKAY;
        case (S_AXI_ARADDR)
            `OFS_OR2_CTRL: rd_next.data = {30'h0, or2_inv_reg};
            `OFS_OR4_CTRL: rd_next.data = {28'h0, or4_inv_reg};
            `OFS_OR8_CTRL: rd_next.data = {24'h0, or8_inv_reg};
            `OFS_OR_IN: rd_next.data = {18'h0, or_in_reg};
            `OFS_OR_STATUS: rd_next.data = {29'h0, EIGHT_INPUT_OR_OUT, FOUR_INPUT_OR_OUT,
                                            TWO_INPUT_OR_OUT};
            `OFS_KEY_GROUP: rd_next.data = {{(32-GW){1'b0}}, group_reg};
            `OFS_KEY_STATUS: rd_next.data = {24'h0, KEY_PRESSED, KEY_FEEDBACK_OUT};
            default: rd_next.resp = `RESP_SLVERR;
        endcase
    end

    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // Read answer registered one cycle after the address is taken
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_next.data;
            S_AXI_RRESP <= rd_next.resp;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

endmodule

// [orkp_keypad.sv]
// Operator keypad and feedback source facing the key pulser
`timescale 1ns/10ps
module orkp_keypad (
    input wire logic CLK, // Scan clock
    input wire logic RST, // Asynchronous reset, active high
    input wire logic [3:0] hold_keys, // Keys the operator holds
    input wire logic [15:0] fb_levels, // Feedback levels, unit major
    output logic [3:0] key_lines, // Key levels to the block
    output logic [15:0] fb_lines // Feedback levels to the block
);
    // Panel levels move only on the scan edge, as a real keypad scan would
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            key_lines <= 4'h0;
            fb_lines <= 16'h0000;
        end else begin
            key_lines <= hold_keys;
            fb_lines <= fb_levels;
        end
    end
endmodule

// [or_gates_and_key_pulser_tb_top.sv]
// Self-checking bench for the OR elements and key pulser
`timescale 1ns/10ps
`include "orkp_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module or_gates_and_key_pulser_tb_top import orkp_pkg::*;;
    logic CLK = 0, RST = 1; // Clock and reset
    logic [11:0] awaddr = 0, araddr = 0; // Bus addresses
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0; // Handshakes
    logic [31:0] wdata = 0; // Write data
    logic [3:0] keys = 0; // Keys held
    logic [15:0] fb = 0; // Feedback levels
    wire logic [3:0] key_lines, fb_out; // Keypad side
    wire logic [15:0] fb_lines, pulse; // Feedback and pulses
    wire logic awready, wready, bvalid, arready, rvalid, or2, or4, or8; // Answers
    wire logic [1:0] bresp, rresp; // Response codes
    wire logic [31:0] rdata; // Read data
    int fail_count = 0, checked = 0, cycles = 0; // Counters
    always #5 CLK = ~CLK;
    or_gates_and_key_pulser dut (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .KEY_PRESSED(key_lines),
        .FEEDBACK_SIGNALS(fb_lines), .KEY_PULSE(pulse), .KEY_FEEDBACK_OUT(fb_out),
        .TWO_INPUT_OR_OUT(or2), .FOUR_INPUT_OR_OUT(or4), .EIGHT_INPUT_OR_OUT(or8));
    orkp_keypad pad (.CLK(CLK), .RST(RST), .hold_keys(keys), .fb_levels(fb),
        .key_lines(key_lines), .fb_lines(fb_lines));
    // Write one word; both channels offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever begin
            @(posedge CLK);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid && bready) break;
        end
        r = bresp;
        bready <= 0;
    endtask
    // Read one word
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge CLK);
            if (arready) arvalid <= 0;
            if (rvalid && rready) break;
        end
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    // Program inversions and operands, then judge all three elements
    task automatic or_case(input logic [1:0] i2, input logic [3:0] i4,
            input logic [7:0] i8, input logic [13:0] op);
        logic [1:0] r;
        logic [31:0] d;
        wr(`OFS_OR2_CTRL, {30'h0, i2}, r);
        wr(`OFS_OR4_CTRL, {28'h0, i4}, r);
        wr(`OFS_OR8_CTRL, {24'h0, i8}, r);
        wr(`OFS_OR_IN, {18'h0, op}, r);
        `CHK("write resp", `RESP_OKAY, r)
        repeat (2) @(posedge CLK);
        #1;
        `CHK("or2", |(op[1:0] ^ i2), or2)
        `CHK("or4", |(op[5:2] ^ i4), or4)
        `CHK("or8", |(op[13:6] ^ i8), or8)
        rd(`OFS_OR_STATUS, d, r);
        `CHK("read resp", `RESP_OKAY, r)
        `CHK("or status", {29'h0, |(op[13:6] ^ i8), |(op[5:2] ^ i4), |(op[1:0] ^ i2)}, d)
    endtask
    // Each key pressed twice in group g: one pulse per press, only on that unit
    task automatic key_group(input logic [1:0] g);
        logic [1:0] r;
        int n;
        logic [31:0] d;
        wr(`OFS_KEY_GROUP, {30'h0, g}, r);
        for (int k = 0; k < 4; k++) repeat (2) begin
            n = 0;
            @(posedge CLK);
            keys <= 4'h1 << k;
            repeat (6) begin
                @(posedge CLK);
                #1;
                if (pulse === 16'h1 << (g * 4 + k)) n++;
                else `CHK("stray pulse", 16'h0, pulse)
            end
            `CHK("pulse count", 1, n)
            @(posedge CLK);
            keys <= 4'h0;
            repeat (3) @(posedge CLK);
        end
        fb <= 16'hC5A3 ^ {4{2'h0, g}};
        repeat (4) @(posedge CLK);
        #1;
        `CHK("feedback", fb[g * 4 +: 4], fb_out)
        rd(`OFS_KEY_GROUP, d, r);
        `CHK("group readback", {30'h0, g}, d)
        rd(`OFS_KEY_STATUS, d, r);
        `CHK("key status", {24'h0, 4'h0, fb[g * 4 +: 4]}, d)
    endtask
    // Reset in mid-run clears outputs and the software-written operands
    task automatic mid_reset;
        logic [1:0] r;
        logic [31:0] d;
        wr(`OFS_OR2_CTRL, 32'h0000_0000, r);
        repeat (2) @(posedge CLK);
        #1;
        `CHK("or2 before reset", 1'b1, or2)
        @(posedge CLK);
        RST <= 1;
        repeat (2) @(posedge CLK);
        RST <= 0;
        #1;
        `CHK("outputs after reset", 19'h0, {pulse, or2, or4, or8})
        rd(`OFS_OR_IN, d, r);
        `CHK("operands after reset", 32'h0, d)
    endtask
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out;
        end
    end
    // Main sequence
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        repeat (5) @(posedge CLK);
        RST <= 0;
        #1;
        `CHK("reset outputs", 19'h0, {pulse, or2, or4, or8})
        for (int i = 0; i < 16; i++) begin
            or_case(i[3:2], 4'hA, 8'hE8,
                {8'hE8 ^ (i[3] ? 8'h00 : 8'h01 << i[2:0]), i[3:0], i[1:0]});
        end
        mid_reset;
        for (int g = 0; g < 4; g++) key_group(g[1:0]);
        rd(12'h020, d, r);
        `CHK("unmapped read resp", `RESP_SLVERR, r)
        `CHK("unmapped read data", 32'h0, d)
        wr(`OFS_KEY_STATUS, 32'h0000_00FF, r);
        `CHK("read-only write resp", `RESP_SLVERR, r)
        close_out;
    end
endmodule
